// File: design/status_indicator_encoder.sv
// Front-panel status indicator encoder
// Assumes all status inputs are synchronous levels on ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "status_indicator_regs.svh"

// Contract
// (RL1) One indicator for fieldbus, diagnosis, each link port; two per field-signal connection.
// (RL2) Logic supply dark without supply, steady green when supply is in order.
// (RL3) Logic supply red while internal supply is below threshold.
// (RL4) Logic supply red while a firmware update runs.
// (RL5) Fieldbus dark when bus runs but safety communication is inactive.
// (RL6) Fieldbus steady green while safety communication is active.
// (RL7) Fieldbus flashes green while operator acknowledgement is required.
// (RL8) Fieldbus steady red on a general fieldbus error.
// (RL9) Fieldbus flashes red on an invalid fieldbus configuration.
// (RL10) Diagnosis dark when ready; steady red while configuration is pending.
// (RL11) Diagnosis flashes red at 1 Hz on system lock-out.
// (RL12) Diagnosis flashes red at 0.5 Hz, 75 percent lit, on field-signal error.
// (RL13) Channel indicator dark when inactive, steady yellow when active.
// (RL14) Channel indicator red when its output is overloaded.
// (RL15) Link port dark when communication is healthy and both outputs off.
// (RL16) Link port steady yellow when both safety switching outputs are active.
// (RL17) Link port flashes red on a communication error.
// (RL18) Output fault monitoring exists only on channel A of connections 7 and 8.
// (RL19) Other flash rates come from a free-running clock divider, fixed per pattern.
// (RL20) Most severe condition wins: errors, then acknowledge or activity, then dark.
module status_indicator_encoder #(
    parameter int unsigned LOCK_PERIOD = 32'(64'(`SI_CLK_FREQ_HZ) * 64'd1000
        / 64'(`SI_LOCK_FLASH_MILLIHZ)),
    parameter int unsigned SIG_PERIOD = 32'(64'(`SI_CLK_FREQ_HZ) * 64'd1000
        / 64'(`SI_SIG_FLASH_MILLIHZ)),
    parameter int unsigned GEN_PERIOD = 32'(64'(`SI_CLK_FREQ_HZ) * 64'd1000
        / 64'(`SI_GEN_FLASH_MILLIHZ))
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic supply_present,
    input wire logic supply_low,
    input wire logic fw_update,
    input wire logic bus_running,
    input wire logic safety_active,
    input wire logic ack_required,
    input wire logic bus_error,
    input wire logic config_invalid,
    input wire logic config_pending,
    input wire logic system_lockout,
    input wire logic signal_error,
    input wire logic [`SI_NUM_LINK-1:0] link_comm_error,
    input wire logic [`SI_NUM_LINK-1:0] first_safety_switching_output,
    input wire logic [`SI_NUM_LINK-1:0] second_safety_switching_output,
    input wire logic [`SI_NUM_CHAN-1:0] channel_active,
    input wire logic [`SI_NUM_CHAN-1:0] channel_overload,
    input wire logic [`SI_NUM_CHAN-1:0] lamp_fault,
    output var status_indicator_pkg::colour_type logic_supply_indicator,
    output var status_indicator_pkg::colour_type reserved_supply_indicator,
    output var status_indicator_pkg::colour_type fieldbus_indicator,
    output var status_indicator_pkg::colour_type diagnosis_indicator,
    output var status_indicator_pkg::colour_type [`SI_NUM_LINK-1:0] link_indicator,
    output var status_indicator_pkg::colour_type [`SI_NUM_CHAN-1:0] channel_indicator
);

    localparam int unsigned NUM_PAT = 3;
    localparam int unsigned PAT_PERIOD [NUM_PAT] = '{LOCK_PERIOD, SIG_PERIOD, GEN_PERIOD};
    localparam int unsigned PAT_ON [NUM_PAT] = '{
        LOCK_PERIOD / 2,
        32'(64'(SIG_PERIOD) * 64'(`SI_SIG_FLASH_ON_PCT) / 64'd100),
        32'(64'(GEN_PERIOD) * 64'(`SI_GEN_FLASH_ON_PCT) / 64'd100)
    };
    localparam logic [`SI_NUM_CHAN-1:0] LAMP_MON = `SI_LAMP_MON_MASK;

    logic [31:0] pat_cnt_r [NUM_PAT];
    logic [NUM_PAT-1:0] flash_r;
    logic [`SI_NUM_CHAN-1:0] lamp_seen;

    // Steady or flashing colour against dark
    function automatic status_indicator_pkg::colour_type flash_colour(
        input logic phase,
        input status_indicator_pkg::colour_type col
    );
        flash_colour = phase ? col : status_indicator_pkg::COL_OFF;
    endfunction

    // Free-running pattern dividers
    genvar p;
    generate
        for (p = 0; p < NUM_PAT; p++) begin : g_pat
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    pat_cnt_r[p] <= 32'h0;
                    flash_r[p] <= 1'b0;
                end else if (ce) begin
                    if (pat_cnt_r[p] >= PAT_PERIOD[p] - 32'd1) begin // RL19
                        pat_cnt_r[p] <= 32'h0;
                    end else begin
                        pat_cnt_r[p] <= pat_cnt_r[p] + 32'd1;
                    end
                    flash_r[p] <= (pat_cnt_r[p] < PAT_ON[p]); // RL11 RL12 RL19
                end
            end
        end
    endgenerate

    // Logic supply indicator
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            logic_supply_indicator <= status_indicator_pkg::COL_OFF;
            reserved_supply_indicator <= status_indicator_pkg::COL_OFF;
        end else if (ce) begin
            reserved_supply_indicator <= status_indicator_pkg::COL_OFF;
            if (!supply_present) begin
                logic_supply_indicator <= status_indicator_pkg::COL_OFF; // RL2
            end else if (supply_low || fw_update) begin
                logic_supply_indicator <= status_indicator_pkg::COL_RED; // RL3 RL4 RL20
            end else begin
                logic_supply_indicator <= status_indicator_pkg::COL_GREEN; // RL2
            end
        end
    end

    // Fieldbus indicator
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fieldbus_indicator <= status_indicator_pkg::COL_OFF;
        end else if (ce) begin
            if (bus_error) begin
                fieldbus_indicator <= status_indicator_pkg::COL_RED; // RL8 RL20
            end else if (config_invalid) begin
                fieldbus_indicator <= flash_colour(flash_r[status_indicator_pkg::PAT_GEN],
                    status_indicator_pkg::COL_RED); // RL9
            end else if (ack_required) begin
                fieldbus_indicator <= flash_colour(flash_r[status_indicator_pkg::PAT_GEN],
                    status_indicator_pkg::COL_GREEN); // RL7
            end else if (bus_running && safety_active) begin
                fieldbus_indicator <= status_indicator_pkg::COL_GREEN; // RL6
            end else begin
                fieldbus_indicator <= status_indicator_pkg::COL_OFF; // RL5
            end
        end
    end

    // Diagnosis indicator
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            diagnosis_indicator <= status_indicator_pkg::COL_OFF;
        end else if (ce) begin
            if (system_lockout) begin
                diagnosis_indicator <= flash_colour(flash_r[status_indicator_pkg::PAT_LOCK],
                    status_indicator_pkg::COL_RED); // RL11 RL20
            end else if (signal_error) begin
                diagnosis_indicator <= flash_colour(flash_r[status_indicator_pkg::PAT_SIG],
                    status_indicator_pkg::COL_RED); // RL12
            end else if (config_pending) begin
                diagnosis_indicator <= status_indicator_pkg::COL_RED; // RL10
            end else begin
                diagnosis_indicator <= status_indicator_pkg::COL_OFF; // RL10
            end
        end
    end

    // Link port indicators
    genvar l;
    generate
        for (l = 0; l < `SI_NUM_LINK; l++) begin : g_link
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    link_indicator[l] <= status_indicator_pkg::COL_OFF;
                end else if (ce) begin
                    if (link_comm_error[l]) begin
                        link_indicator[l] <= flash_colour(
                            flash_r[status_indicator_pkg::PAT_GEN],
                            status_indicator_pkg::COL_RED); // RL17 RL20
                    end else if (first_safety_switching_output[l]
                            && second_safety_switching_output[l]) begin
                        link_indicator[l] <= status_indicator_pkg::COL_YELLOW; // RL16
                    end else begin
                        link_indicator[l] <= status_indicator_pkg::COL_OFF; // RL15
                    end
                end
            end
        end
    endgenerate

    // Lamp fault only seen where monitoring exists
    assign lamp_seen = lamp_fault & LAMP_MON; // RL18

    // Field-signal channel indicators, two per connection
    genvar c;
    generate
        for (c = 0; c < `SI_NUM_CHAN; c++) begin : g_chan // RL1
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    channel_indicator[c] <= status_indicator_pkg::COL_OFF;
                end else if (ce) begin
                    if (channel_overload[c] || lamp_seen[c]) begin
                        channel_indicator[c] <= status_indicator_pkg::COL_RED; // RL14 RL20
                    end else if (channel_active[c]) begin
                        channel_indicator[c] <= status_indicator_pkg::COL_YELLOW; // RL13
                    end else begin
                        channel_indicator[c] <= status_indicator_pkg::COL_OFF; // RL13
                    end
                end
            end
        end
    endgenerate

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    sequence supply_ok_s;
        ce && supply_present && !supply_low && !fw_update;
    endsequence

    sequence bus_quiet_s;
        ce && !bus_error && !config_invalid && !ack_required;
    endsequence

    sequence frozen_s;
        !ce ##1 1'b1;
    endsequence

    sequence diag_quiet_s;
        ce && !system_lockout && !signal_error;
    endsequence

    supply_dark_a: assert property ( // RL2
        ce && !supply_present |=> logic_supply_indicator == status_indicator_pkg::COL_OFF)
        else $error("Supply indicator not dark without supply");

    supply_green_a: assert property ( // RL2
        supply_ok_s |=> logic_supply_indicator == status_indicator_pkg::COL_GREEN)
        else $error("Supply indicator not green with good supply");

    supply_low_a: assert property ( // RL3
        ce && supply_present && supply_low
        |=> logic_supply_indicator == status_indicator_pkg::COL_RED)
        else $error("Supply indicator not red on low supply");

    fw_update_a: assert property ( // RL4
        ce && supply_present && fw_update
        |=> logic_supply_indicator == status_indicator_pkg::COL_RED)
        else $error("Supply indicator not red during update");

    bus_dark_a: assert property ( // RL5
        bus_quiet_s and (bus_running && !safety_active)
        |=> fieldbus_indicator == status_indicator_pkg::COL_OFF)
        else $error("Fieldbus indicator lit without safety link");

    bus_green_a: assert property ( // RL6
        bus_quiet_s and (bus_running && safety_active)
        |=> fieldbus_indicator == status_indicator_pkg::COL_GREEN)
        else $error("Fieldbus indicator not green with safety link");

    ack_flash_a: assert property ( // RL7
        ce && ack_required && !bus_error && !config_invalid
        |=> fieldbus_indicator == ($past(flash_r[2]) ? status_indicator_pkg::COL_GREEN
            : status_indicator_pkg::COL_OFF))
        else $error("Fieldbus indicator not flashing green");

    bus_error_a: assert property ( // RL8
        ce && bus_error |=> fieldbus_indicator == status_indicator_pkg::COL_RED)
        else $error("Fieldbus indicator not red on bus error");

    cfg_flash_a: assert property ( // RL9
        ce && config_invalid && !bus_error
        |=> fieldbus_indicator == ($past(flash_r[2]) ? status_indicator_pkg::COL_RED
            : status_indicator_pkg::COL_OFF))
        else $error("Fieldbus indicator not flashing red");

    diag_pending_a: assert property ( // RL10
        ce && config_pending && !system_lockout && !signal_error
        |=> diagnosis_indicator == status_indicator_pkg::COL_RED)
        else $error("Diagnosis indicator not red while pending");

    lock_phase_a: assert property ( // RL11
        ce && (pat_cnt_r[0] == LOCK_PERIOD / 2)
        |=> !flash_r[0] ##0 pat_cnt_r[0] == LOCK_PERIOD / 2 + 1)
        else $error("Lock-out flash phase wrong");

    sig_duty_a: assert property ( // RL12
        ce && pat_cnt_r[1] < PAT_ON[1] |=> flash_r[1])
        else $error("Field-signal flash lit share wrong");

    lamp_mask_a: assert property ( // RL18
        ce && lamp_fault[0] && !channel_overload[0] && channel_active[0]
        |=> channel_indicator[0] == status_indicator_pkg::COL_YELLOW)
        else $error("Unmonitored channel shows lamp fault");

    overload_a: assert property ( // RL14
        ce && channel_overload[12] |=> channel_indicator[12] == status_indicator_pkg::COL_RED)
        else $error("Channel indicator not red on overload");

    link_yellow_a: assert property ( // RL16
        ce && !link_comm_error[0] && first_safety_switching_output[0]
        && second_safety_switching_output[0]
        |=> link_indicator[0] == status_indicator_pkg::COL_YELLOW)
        else $error("Link indicator not yellow with both outputs on");

    freeze_a: assert property ( // RL19
        frozen_s |-> $stable(flash_r) && $stable(diagnosis_indicator))
        else $error("State changed while clock enable low");

    lock_flash_a: assert property ( // RL11
        ce && system_lockout
        |=> diagnosis_indicator == ($past(flash_r[0]) ? status_indicator_pkg::COL_RED
            : status_indicator_pkg::COL_OFF))
        else $error("Diagnosis indicator not flashing on lock-out");

    sig_flash_a: assert property ( // RL12
        ce && signal_error && !system_lockout
        |=> diagnosis_indicator == ($past(flash_r[1]) ? status_indicator_pkg::COL_RED
            : status_indicator_pkg::COL_OFF))
        else $error("Diagnosis indicator not flashing on field-signal error");

    diag_ready_a: assert property ( // RL10
        diag_quiet_s and !config_pending
        |=> diagnosis_indicator == status_indicator_pkg::COL_OFF)
        else $error("Diagnosis indicator lit while ready");

    sig_wrap_a: assert property ( // RL19
        ce && pat_cnt_r[1] == SIG_PERIOD - 1 |=> pat_cnt_r[1] == 32'h0)
        else $error("Field-signal flash period wrong");

    link_flash_a: assert property ( // RL17
        ce && link_comm_error[0]
        |=> link_indicator[0] == ($past(flash_r[2]) ? status_indicator_pkg::COL_RED
            : status_indicator_pkg::COL_OFF))
        else $error("Link indicator not flashing red on error");

    link_dark_a: assert property ( // RL15
        ce && !link_comm_error[1]
        && !(first_safety_switching_output[1] && second_safety_switching_output[1])
        |=> link_indicator[1] == status_indicator_pkg::COL_OFF)
        else $error("Link indicator lit while healthy and outputs off");

    chan_yellow_a: assert property ( // RL13
        ce && channel_active[3] && !channel_overload[3]
        |=> channel_indicator[3] == status_indicator_pkg::COL_YELLOW)
        else $error("Active channel indicator not yellow");

    chan_dark_a: assert property ( // RL13
        ce && !channel_active[5] && !channel_overload[5]
        |=> channel_indicator[5] == status_indicator_pkg::COL_OFF)
        else $error("Inactive channel indicator lit");

    lamp_fault_a: assert property ( // RL18
        ce && lamp_fault[14] |=> channel_indicator[14] == status_indicator_pkg::COL_RED)
        else $error("Monitored lamp fault not shown red");

endmodule // status_indicator_encoder
`default_nettype wire

// File: design/status_indicator_regs.svh
// Timing and mask constants for the status indicator encoder
// Assumes a 250 MHz system clock; no software-visible registers
`ifndef STATUS_INDICATOR_REGS_SVH
`define STATUS_INDICATOR_REGS_SVH

// System clock rate in hertz
`define SI_CLK_FREQ_HZ 250000000
// Lock-out flash rate in millihertz
`define SI_LOCK_FLASH_MILLIHZ 1000
// Field-signal error flash rate in millihertz
`define SI_SIG_FLASH_MILLIHZ 500
// Field-signal error flash lit share in percent
`define SI_SIG_FLASH_ON_PCT 75
// Generic flash rate in millihertz
`define SI_GEN_FLASH_MILLIHZ 2000
// Generic flash lit share in percent
`define SI_GEN_FLASH_ON_PCT 50
// Channels whose output has fault monitoring: 7A and 8A
`define SI_LAMP_MON_MASK 16'h5000
// Field-signal connection count, total channel count and link port count
`define SI_NUM_CONN 8
`define SI_NUM_CHAN 16
`define SI_NUM_LINK 2

`endif

// File: design/status_indicator_pkg.sv
// Types shared by the status indicator encoder
// Assumes the timing header is included by the design
`default_nettype none

package status_indicator_pkg;

    typedef enum logic [1:0] {
        COL_OFF,
        COL_GREEN,
        COL_RED,
        COL_YELLOW
    } colour_type;

    typedef enum logic [1:0] {
        PAT_LOCK,
        PAT_SIG,
        PAT_GEN
    } pattern_type;

endpackage

`default_nettype wire

// File: tb/lamp_viewer.sv
// Operator view of one indicator: counts lit and dark cycles
// Assumes clear is driven synchronously to ref_clk
`timescale 1ns/1ps
`default_nettype none

module lamp_viewer (
    input wire logic ref_clk,
    input wire logic clear,
    input wire status_indicator_pkg::colour_type lamp,
    input wire status_indicator_pkg::colour_type lit_col,
    output logic [15:0] lit_cnt,
    output logic [15:0] dark_cnt
);
    // Lit in the watched colour, dark when off
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            lit_cnt <= 16'h0000;
            dark_cnt <= 16'h0000;
        end else if (lamp == lit_col) begin
            lit_cnt <= lit_cnt + 16'h0001;
        end else if (lamp == status_indicator_pkg::COL_OFF) begin
            dark_cnt <= dark_cnt + 16'h0001;
        end
    end
endmodule // lamp_viewer

`default_nettype wire

// File: tb/status_indicator_encoder_test.sv
// Self-checking bench for the status indicator encoder
// Assumes short flash periods 8, 16 and 4 cycles
`timescale 1ns/1ps
`default_nettype none
`include "status_indicator_regs.svh"

module status_indicator_encoder_test;
    typedef status_indicator_pkg::colour_type colour_type;
    localparam colour_type COL_OFF = status_indicator_pkg::COL_OFF;
    localparam colour_type COL_GREEN = status_indicator_pkg::COL_GREEN;
    localparam colour_type COL_RED = status_indicator_pkg::COL_RED;
    localparam colour_type COL_YELLOW = status_indicator_pkg::COL_YELLOW;
    logic ref_clk, srst, ce, supply_present, supply_low, fw_update, bus_running;
    logic safety_active, ack_required, bus_error, config_invalid, config_pending;
    logic system_lockout, signal_error, view_clear;
    logic [1:0] link_comm_error, first_ssw, second_ssw, view_sel;
    logic [15:0] channel_active, channel_overload, lamp_fault, lit_cnt, dark_cnt;
    colour_type ls, rs, fb, dg, watched, lit_col;
    colour_type [1:0] lk;
    colour_type [15:0] ch;
    int err_count, checks_done, cycles;

    status_indicator_encoder #(.LOCK_PERIOD(8), .SIG_PERIOD(16), .GEN_PERIOD(4))
    i_status_indicator_encoder (
        .ref_clk(ref_clk), .srst(srst), .ce(ce), .supply_present(supply_present),
        .supply_low(supply_low), .fw_update(fw_update), .bus_running(bus_running),
        .safety_active(safety_active), .ack_required(ack_required),
        .bus_error(bus_error), .config_invalid(config_invalid),
        .config_pending(config_pending), .system_lockout(system_lockout),
        .signal_error(signal_error), .link_comm_error(link_comm_error),
        .first_safety_switching_output(first_ssw),
        .second_safety_switching_output(second_ssw),
        .channel_active(channel_active), .channel_overload(channel_overload),
        .lamp_fault(lamp_fault), .logic_supply_indicator(ls),
        .reserved_supply_indicator(rs), .fieldbus_indicator(fb),
        .diagnosis_indicator(dg), .link_indicator(lk), .channel_indicator(ch));

    lamp_viewer i_lamp_viewer (.ref_clk(ref_clk), .clear(view_clear), .lamp(watched),
        .lit_col(lit_col), .lit_cnt(lit_cnt), .dark_cnt(dark_cnt));

    always_comb begin
        case (view_sel)
            2'h0: watched = fb;
            2'h1: watched = dg;
            default: watched = lk[0];
        endcase
    end

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Whole periods only, so the lit count is independent of phase
    task automatic flash(input string what, input logic [1:0] sel, input colour_type col,
        input int n, input logic [15:0] exp_lit);
        view_sel = sel;
        lit_col = col;
        view_clear = 1'b1;
        step(4);
        view_clear = 1'b0;
        step(n);
        check({what, " lit"}, exp_lit, lit_cnt);
        check({what, " dark"}, 16'(n) - exp_lit, dark_cnt);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic t_supply();
        supply_present = 1'b0;
        step(1);
        check("supply off", COL_OFF, ls);
        check("reserved", COL_OFF, rs);
        supply_present = 1'b1;
        step(1);
        check("supply ok", COL_GREEN, ls);
        supply_low = 1'b1;
        step(1);
        check("supply low", COL_RED, ls);
        supply_low = 1'b0;
        fw_update = 1'b1;
        step(1);
        check("fw update", COL_RED, ls);
        fw_update = 1'b0;
        ce = 1'b0;
        step(3);
        check("frozen", COL_RED, ls);
        ce = 1'b1;
        step(1);
        check("unfrozen", COL_GREEN, ls);
    endtask

    task automatic t_bus();
        bus_running = 1'b1;
        step(1);
        check("bus no safety", COL_OFF, fb);
        safety_active = 1'b1;
        step(1);
        check("bus safety", COL_GREEN, fb);
        config_invalid = 1'b1;
        flash("bad config", 2'h0, COL_RED, 32, 16'h0010);
        bus_error = 1'b1;
        step(1);
        check("bus error", COL_RED, fb);
        bus_error = 1'b0;
        config_invalid = 1'b0;
        ack_required = 1'b1;
        flash("ack", 2'h0, COL_GREEN, 32, 16'h0010);
        ack_required = 1'b0;
    endtask

    task automatic t_diag();
        step(1);
        check("diag ready", COL_OFF, dg);
        config_pending = 1'b1;
        step(1);
        check("diag pending", COL_RED, dg);
        signal_error = 1'b1;
        flash("signal err", 2'h1, COL_RED, 64, 16'h0030);
        system_lockout = 1'b1;
        flash("lockout", 2'h1, COL_RED, 64, 16'h0020);
        {config_pending, signal_error, system_lockout} = 3'h0;
        step(1);
        check("diag clear", COL_OFF, dg);
    endtask

    task automatic t_link();
        first_ssw = 2'h3;
        second_ssw = 2'h1;
        step(1);
        check("link both on", COL_YELLOW, lk[0]);
        check("link one on", COL_OFF, lk[1]);
        link_comm_error = 2'h1;
        flash("link err", 2'h2, COL_RED, 32, 16'h0010);
        check("link other", COL_OFF, lk[1]);
        {link_comm_error, first_ssw, second_ssw} = 6'h00;
    endtask

    task automatic t_chan();
        for (int i = 0; i < `SI_NUM_CHAN; i++) begin
            channel_active = 16'h0001 << i;
            step(1);
            check("chan active", COL_YELLOW, ch[i]);
            check("chan idle", COL_OFF, ch[(i + 1) % `SI_NUM_CHAN]);
            channel_overload = 16'h0001 << i;
            step(1);
            check("chan overload", COL_RED, ch[i]);
            channel_overload = 16'h0000;
            lamp_fault = 16'h0001 << i;
            step(1);
            check("lamp fault", (i == 12 || i == 14) ? COL_RED : COL_YELLOW, ch[i]);
            lamp_fault = 16'h0000;
        end
        channel_active = 16'h0000;
    endtask

    task automatic t_reset();
        channel_active = 16'hFFFF;
        step(1);
        check("chan before reset", COL_YELLOW, ch[0]);
        srst = 1'b1;
        step(1);
        check("reset supply", COL_OFF, ls);
        check("reset chan", COL_OFF, ch[0]);
        srst = 1'b0;
        step(1);
        check("chan after reset", COL_YELLOW, ch[15]);
        channel_active = 16'h0000;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles >= 3000) begin
            err_count++;
            $display("mismatch timeout expected done seen hang");
            conclude();
        end
    end

    initial begin
        {srst, ce, view_clear} = 3'h7;
        {supply_present, supply_low, fw_update, bus_running, safety_active} = 5'h10;
        {ack_required, bus_error, config_invalid, config_pending} = 4'h0;
        {system_lockout, signal_error, link_comm_error} = 4'h0;
        {first_ssw, second_ssw, view_sel} = 6'h00;
        {channel_active, channel_overload, lamp_fault} = 48'h0;
        lit_col = COL_RED;
        err_count = 0;
        checks_done = 0;
        cycles = 0;
        step(12);
        srst = 1'b0;
        t_supply();
        t_bus();
        t_diag();
        t_link();
        t_chan();
        t_reset();
        conclude();
    end
endmodule // status_indicator_encoder_test

`default_nettype wire
